// ===== include/emem_cfg.svh
// Register offsets, field positions and reset values of the memory port.
`ifndef EMEM_CFG_SVH
`define EMEM_CFG_SVH
`define OFF_WAIT_CFG 32'hF0000004
`define OFF_SDRAM_CFG 32'hF0000008
`define OFF_SDRAM_REF 32'hF000000C
`define OFF_ASYNC_CFG 32'hF0000010
`define OFF_SDRAM_TIM 32'hF0000020
`define OFF_SDRAM_SRX 32'hF000003C
`define OFF_IRQ_RAW 32'hF0000040
`define OFF_IRQ_MSKD 32'hF0000044
`define OFF_IRQ_MSET 32'hF0000048
`define OFF_IRQ_MCLR 32'hF000004C
`define OFF_NAND_CTL 32'hF0000060
`define OFF_NAND_STS 32'hF0000064
`define OFF_NAND_ECC 32'hF0000070
`define BIT_WAIT_POL 28
`define BIT_SD_WIDTH 14
`define LSB_ASYNC_WIDTH 0
`define BIT_NAND_EN 0
`define BIT_ECC_START 8
`define BIT_IRQ_WAIT 2
`define ECC_BLOCK_BYTES 12'h200
`define SDRAM_BURST_BYTES 5'h10
`define DATA_BUS_BITS 32
`define RST_WAIT_CFG 32'h000000FF
`define RST_SDRAM_CFG 32'h00004720
`define RST_ASYNC_CFG 32'h3FFFFFFD
`define RST_ZERO 32'h00000000
`endif

// ===== include/emem_pkg.sv
// Types shared by the external memory port configuration block.
package emem_pkg;
	typedef enum logic [1:0] {
		WIDTH8,
		WIDTH16,
		WIDTH32,
		WIDTHBAD
	} bus_width_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef enum {
		ECC_IDLE,
		ECC_RUN
	} ecc_state_t;
	typedef struct packed {
		logic [31:0] waitCfg;
		logic [31:0] sdramCfg;
		logic [31:0] sdramRef;
		logic [31:0] asyncCfg;
		logic [31:0] sdramTim;
		logic [31:0] sdramSrx;
		logic [31:0] nandCtl;
		logic [2:0] irqRaw;
		logic [2:0] irqMask;
		logic [1:0] waitSync;
		logic waitPrev;
		logic waitActive;
		logic irqOut;
		logic [31:0] rdata;
		ecc_state_t eccState;
		logic [11:0] eccCount;
		logic [31:0] eccParity;
		logic [1:0] bankSel;
		logic [12:0] addrOut;
		logic sdramCs;
		logic asyncCs;
		logic [4:0] burstBytes;
	} emem_state_t;
endpackage : emem_pkg

// ===== core/emem_port_cfg.sv
// External memory port configuration, wait pin interrupt and NAND ECC.
`timescale 1ns/10ps
`default_nettype none
`include "emem_cfg.svh"
module emem_port_cfg
	import emem_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	input wire logic externalWaitPin,
	input wire logic asyncAccess,
	input wire logic sdramAccess,
	input wire logic [14:0] accessAddr,
	input wire logic eccDataValid,
	input wire logic [31:0] eccData,
	output logic [1:0] bankSelectOutputs,
	output logic [12:0] memoryAddressOutputs,
	output logic sdramChipSelect,
	output logic asyncChipSelect,
	output logic waitActive,
	output logic [4:0] sdramBurstBytes,
	output logic nonmaskableInterruptLine
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	emem_state_t cur_ff;
	emem_state_t nxt_ff;
	reg_req_t req;
	logic waitRise;
	logic waitLevel;
	bus_width_t sdWidth;
	bus_width_t asWidth;
	logic nandMode;
	logic [2:0] pend;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
		hit = (a == off);
	endfunction : hit

	always_comb begin
		req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_ff = cur_ff;
		// Pin passes two flip-flops before anything looks at it.
		nxt_ff.waitSync = {cur_ff.waitSync[0], externalWaitPin};
		nxt_ff.waitPrev = cur_ff.waitSync[1];
		// Edge found from synchronised samples only; a pulse shorter than
		// one cycle may be missed, which the source must avoid.
		waitRise = cur_ff.waitSync[1] & ~cur_ff.waitPrev;
		waitLevel = cur_ff.waitSync[1] ^ cur_ff.waitCfg[`BIT_WAIT_POL];
		nxt_ff.waitActive = waitLevel;
		sdWidth = cur_ff.sdramCfg[`BIT_SD_WIDTH] ? WIDTH16 : WIDTH32;
		asWidth = bus_width_t'(cur_ff.asyncCfg[`LSB_ASYNC_WIDTH +: 2]);
		nandMode = cur_ff.nandCtl[`BIT_NAND_EN];

		// Register writes.
		if (req.wr) begin
			if (hit(req.addr, `OFF_WAIT_CFG)) begin
				nxt_ff.waitCfg = req.wdata;
			end
			if (hit(req.addr, `OFF_SDRAM_CFG)) begin
				nxt_ff.sdramCfg = req.wdata;
			end
			if (hit(req.addr, `OFF_SDRAM_REF)) begin
				nxt_ff.sdramRef = req.wdata;
			end
			if (hit(req.addr, `OFF_ASYNC_CFG)) begin
				nxt_ff.asyncCfg = req.wdata;
				if (req.wdata[1:0] == 2'h3) begin
					nxt_ff.asyncCfg[1:0] = 2'h2;
				end
				// NAND only goes to 16 bits; a 32-bit pick falls back.
				if (nandMode && req.wdata[1:0] != 2'h0) begin
					nxt_ff.asyncCfg[1:0] = 2'h1;
				end
			end
			if (hit(req.addr, `OFF_SDRAM_TIM)) begin
				nxt_ff.sdramTim = req.wdata;
			end
			if (hit(req.addr, `OFF_SDRAM_SRX)) begin
				nxt_ff.sdramSrx = req.wdata;
			end
			if (hit(req.addr, `OFF_NAND_CTL)) begin
				nxt_ff.nandCtl = req.wdata;
			end
			if (hit(req.addr, `OFF_IRQ_MSET)) begin
				nxt_ff.irqMask = cur_ff.irqMask | req.wdata[2:0];
			end
			if (hit(req.addr, `OFF_IRQ_MCLR)) begin
				nxt_ff.irqMask = cur_ff.irqMask & ~req.wdata[2:0];
			end
		end

		// Sticky status; a new edge wins over a write-one clear.
		pend = cur_ff.irqRaw;
		if (req.wr && (hit(req.addr, `OFF_IRQ_RAW)
			|| hit(req.addr, `OFF_IRQ_MSKD))) begin
			pend = pend & ~req.wdata[2:0];
		end
		if (waitRise) begin
			pend[`BIT_IRQ_WAIT] = 1'b1;
		end
		nxt_ff.irqRaw = pend;
		nxt_ff.irqOut = |(pend & cur_ff.irqMask);

		// ECC over one block, closed at the block limit.
		case (cur_ff.eccState)
			ECC_IDLE: begin
				if (req.wr && hit(req.addr, `OFF_NAND_CTL)
					&& req.wdata[`BIT_ECC_START]) begin
					nxt_ff.eccState = ECC_RUN;
					nxt_ff.eccCount = 12'h000;
					nxt_ff.eccParity = 32'h00000000;
				end
			end
			ECC_RUN: begin
				if (eccDataValid) begin
					nxt_ff.eccParity = cur_ff.eccParity ^ eccData;
					nxt_ff.eccCount = cur_ff.eccCount + 12'h004;
					if (cur_ff.eccCount + 12'h004 >= `ECC_BLOCK_BYTES) begin
						nxt_ff.eccState = ECC_IDLE;
					end
				end
			end
			default: begin
				nxt_ff.eccState = ECC_IDLE;
			end
		endcase

		// Pin-side address mapping.
		nxt_ff.sdramCs = 1'b0;
		nxt_ff.asyncCs = 1'b0;
		nxt_ff.bankSel = 2'h0;
		nxt_ff.addrOut = accessAddr[14:2];
		// 8-bit SDRAM cannot be set, so any SDRAM access is x16/x32.
		if (sdramAccess) begin
			nxt_ff.sdramCs = 1'b1;
			nxt_ff.bankSel = accessAddr[14:13];
			nxt_ff.addrOut = accessAddr[12:0];
		end else if (asyncAccess) begin
			nxt_ff.asyncCs = 1'b1;
			case (asWidth)
				WIDTH8: begin
					nxt_ff.bankSel = accessAddr[1:0];
					nxt_ff.addrOut = accessAddr[14:2];
				end
				WIDTH16: begin
					nxt_ff.bankSel = {accessAddr[0], 1'b0};
					nxt_ff.addrOut = accessAddr[13:1];
				end
				default: begin
					nxt_ff.bankSel = 2'h0;
					nxt_ff.addrOut = accessAddr[12:0];
				end
			endcase
		end
		nxt_ff.burstBytes = `SDRAM_BURST_BYTES;

		// Read data, one cycle after the strobe. The data bus is always
		// 32 bits wide, so the width field only shapes the pin mapping.
		nxt_ff.rdata = 32'h00000000;
		if (req.rd) begin
			if (hit(req.addr, `OFF_WAIT_CFG)) begin
				nxt_ff.rdata = cur_ff.waitCfg;
			end else if (hit(req.addr, `OFF_SDRAM_CFG)) begin
				nxt_ff.rdata = {cur_ff.sdramCfg[31:15],
					sdWidth == WIDTH16, cur_ff.sdramCfg[13:0]};
			end else if (hit(req.addr, `OFF_SDRAM_REF)) begin
				nxt_ff.rdata = cur_ff.sdramRef;
			end else if (hit(req.addr, `OFF_ASYNC_CFG)) begin
				nxt_ff.rdata = cur_ff.asyncCfg;
			end else if (hit(req.addr, `OFF_SDRAM_TIM)) begin
				nxt_ff.rdata = cur_ff.sdramTim;
			end else if (hit(req.addr, `OFF_SDRAM_SRX)) begin
				nxt_ff.rdata = cur_ff.sdramSrx;
			end else if (hit(req.addr, `OFF_IRQ_RAW)) begin
				nxt_ff.rdata = {29'h0, cur_ff.irqRaw};
			end else if (hit(req.addr, `OFF_IRQ_MSKD)) begin
				nxt_ff.rdata = {29'h0, cur_ff.irqRaw & cur_ff.irqMask};
			end else if (hit(req.addr, `OFF_IRQ_MSET)
				|| hit(req.addr, `OFF_IRQ_MCLR)) begin
				nxt_ff.rdata = {29'h0, cur_ff.irqMask};
			end else if (hit(req.addr, `OFF_NAND_CTL)) begin
				nxt_ff.rdata = cur_ff.nandCtl;
			end else if (hit(req.addr, `OFF_NAND_STS)) begin
				nxt_ff.rdata = {cur_ff.eccState == ECC_RUN, 19'h0,
					cur_ff.eccCount[11:0]};
				nxt_ff.rdata[0] = cur_ff.waitSync[1];
			end else if (hit(req.addr, `OFF_NAND_ECC)) begin
				nxt_ff.rdata = cur_ff.eccParity;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			cur_ff <= '0;
			cur_ff.waitCfg <= `RST_WAIT_CFG;
			cur_ff.sdramCfg <= `RST_SDRAM_CFG;
			cur_ff.asyncCfg <= `RST_ASYNC_CFG;
			// Wait interrupt starts masked.
			cur_ff.irqMask <= 3'h0;
			cur_ff.eccState <= ECC_IDLE;
			cur_ff.burstBytes <= `SDRAM_BURST_BYTES;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	always_comb begin
		regRdata = cur_ff.rdata;
		bankSelectOutputs = cur_ff.bankSel;
		memoryAddressOutputs = cur_ff.addrOut;
		sdramChipSelect = cur_ff.sdramCs;
		asyncChipSelect = cur_ff.asyncCs;
		waitActive = cur_ff.waitActive;
		sdramBurstBytes = cur_ff.burstBytes;
		nonmaskableInterruptLine = cur_ff.irqOut;
	end
endmodule : emem_port_cfg
`default_nettype wire

// ===== tb/wait_source.sv
// Model of the outside party that drives the wait pin.
`timescale 1ns/10ps
`default_nettype none
module wait_source (
	input wire logic clk,
	input wire logic go,
	output logic pin
);
	logic [1:0] holdCnt_ff = 2'h0;
	// A short pulse can be missed by the synchroniser, so hold three cycles.
	always_ff @(posedge clk) begin
		if (go) begin
			holdCnt_ff <= 2'h3;
		end else if (holdCnt_ff != 2'h0) begin
			holdCnt_ff <= holdCnt_ff - 2'h1;
		end
	end
	assign pin = (holdCnt_ff != 2'h0);
endmodule : wait_source
`default_nettype wire

// ===== tb/emem_port_cfg_sva.sv
// Port checker for the memory port configuration block.
`timescale 1ns/10ps
`default_nettype none
module emem_port_cfg_chk (
	input wire logic clk,
	input wire logic srst,
	input wire logic regWr,
	input wire logic externalWaitPin,
	input wire logic asyncAccess,
	input wire logic sdramAccess,
	input wire logic [14:0] accessAddr,
	input wire logic [1:0] bankSelectOutputs,
	input wire logic sdramChipSelect,
	input wire logic asyncChipSelect,
	input wire logic [4:0] sdramBurstBytes,
	input wire logic nonmaskableInterruptLine
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_asyncReq;
		asyncAccess && !sdramAccess;
	endsequence
	property p_burst;
		sdramBurstBytes == 5'h10;
	endproperty
	property p_sdCs;
		sdramAccess |=> sdramChipSelect && !asyncChipSelect;
	endproperty
	property p_asCs;
		s_asyncReq |=> asyncChipSelect;
	endproperty
	property p_idle;
		!asyncAccess && !sdramAccess |=> !sdramChipSelect && !asyncChipSelect;
	endproperty
	property p_bank;
		s_asyncReq |=> bankSelectOutputs == $past(accessAddr[1:0])
			|| bankSelectOutputs == {$past(accessAddr[0]), 1'b0}
			|| bankSelectOutputs == 2'h0;
	endproperty
	property p_excl;
		!(sdramChipSelect && asyncChipSelect);
	endproperty
	// A new interrupt needs a recent wait edge or a register write behind it.
	property p_rise;
		$rose(nonmaskableInterruptLine) |-> $past(regWr) || $past(regWr, 2)
			|| $past(externalWaitPin, 3) || $past(externalWaitPin, 5);
	endproperty
	property p_fall;
		$fell(nonmaskableInterruptLine) |-> $past(regWr) || $past(regWr, 2);
	endproperty
	a_burst: assert property (p_burst) else $error("burst size");
	a_sdCs: assert property (p_sdCs) else $error("sdram select");
	a_asCs: assert property (p_asCs) else $error("async select");
	a_idle: assert property (p_idle) else $error("idle select");
	a_bank: assert property (p_bank) else $error("bank bits");
	a_excl: assert property (p_excl) else $error("both selects");
	a_rise: assert property (p_rise) else $error("irq rise");
	a_fall: assert property (p_fall) else $error("irq fall");
endmodule : emem_port_cfg_chk
bind emem_port_cfg emem_port_cfg_chk chk (.clk(clk), .srst(srst),
	.regWr(regWr), .externalWaitPin(externalWaitPin),
	.asyncAccess(asyncAccess), .sdramAccess(sdramAccess),
	.accessAddr(accessAddr), .bankSelectOutputs(bankSelectOutputs),
	.sdramChipSelect(sdramChipSelect), .asyncChipSelect(asyncChipSelect),
	.sdramBurstBytes(sdramBurstBytes),
	.nonmaskableInterruptLine(nonmaskableInterruptLine));
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the memory port configuration block.
`timescale 1ns/10ps
`default_nettype none
`include "emem_cfg.svh"
module tb_top;
	logic clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, go = 1'b0;
	logic [31:0] regAddr = 32'h0, regWdata = 32'h0, regRdata;
	logic asyncAccess = 1'b0, sdramAccess = 1'b0, pin, sdCs, asCs, wAct, irq;
	logic [14:0] accessAddr = 15'h0;
	logic eccValid = 1'b0;
	logic [31:0] eccWord = 32'h0;
	logic [1:0] bank;
	logic [12:0] maddr;
	logic [4:0] burst;
	int errors = 0, total_checks = 0;
	initial forever #5 clk = ~clk;
	wait_source ws (.clk(clk), .go(go), .pin(pin));
	emem_port_cfg dut (.clk(clk), .srst(srst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .externalWaitPin(pin), .asyncAccess(asyncAccess),
		.sdramAccess(sdramAccess), .accessAddr(accessAddr),
		.eccDataValid(eccValid), .eccData(eccWord), .bankSelectOutputs(bank),
		.memoryAddressOutputs(maddr), .sdramChipSelect(sdCs),
		.asyncChipSelect(asCs), .waitActive(wAct), .sdramBurstBytes(burst),
		.nonmaskableInterruptLine(irq));
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic wr(logic [31:0] a, logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(logic [31:0] a, logic [31:0] e, string n);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(n, regRdata, e);
	endtask : rd
	task automatic irqIs(int n, logic e);
		repeat (n) @(posedge clk);
		#1 chk("irq", {31'h0, irq}, {31'h0, e});
	endtask : irqIs
	task automatic pulse;
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask : pulse
	task automatic acc(logic s, logic [14:0] a, logic [1:0] b, logic [12:0] m);
		@(posedge clk);
		sdramAccess <= s;
		asyncAccess <= 1'b1;
		accessAddr <= a;
		@(posedge clk);
		#1 chk("sdCs", {31'h0, sdCs}, {31'h0, s});
		chk("asCs", {31'h0, asCs}, {31'h0, !s});
		if (!s) begin
			chk("bank", {30'h0, bank}, {30'h0, b});
			chk("addr", {19'h0, maddr}, {19'h0, m});
		end
		sdramAccess <= 1'b0;
		asyncAccess <= 1'b0;
	endtask : acc
	task final_report;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	initial begin
		#20000;
		errors++;
		final_report;
	end
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(`OFF_WAIT_CFG, `RST_WAIT_CFG, "waitCfg");
		rd(`OFF_SDRAM_CFG, `RST_SDRAM_CFG, "sdramCfg");
		rd(`OFF_IRQ_MSKD, `RST_ZERO, "masked");
		rd(32'hF0000000, `RST_ZERO, "unmapped");
		$display("test reset done");
		pulse;
		irqIs(6, 1'b0);
		rd(`OFF_IRQ_RAW, 32'h00000004, "raw");
		wr(`OFF_IRQ_MSET, 32'h00000000);
		irqIs(2, 1'b0);
		wr(`OFF_IRQ_MSET, 32'h00000004);
		irqIs(2, 1'b1);
		rd(`OFF_IRQ_MSKD, 32'h00000004, "masked");
		wr(`OFF_IRQ_RAW, 32'h00000004);
		irqIs(2, 1'b0);
		wr(`OFF_WAIT_CFG, 32'h100000FF);
		irqIs(3, 1'b0);
		chk("waitActive", {31'h0, wAct}, 32'h1);
		pulse;
		irqIs(6, 1'b1);
		wr(`OFF_IRQ_MCLR, 32'h00000004);
		irqIs(2, 1'b0);
		$display("test wait done");
		acc(1'b0, 15'h2AAB, 2'h2, 13'h1555);
		wr(`OFF_ASYNC_CFG, 32'h3FFFFFFC);
		acc(1'b0, 15'h2AAB, 2'h3, 13'h0AAA);
		acc(1'b1, 15'h2AAB, 2'h0, 13'h0);
		chk("burst", {27'h0, burst}, 32'h10);
		wr(`OFF_ASYNC_CFG, 32'h3FFFFFFF);
		rd(`OFF_ASYNC_CFG, 32'h3FFFFFFE, "asyncCfg");
		$display("test access done");
		wr(`OFF_NAND_CTL, 32'h00000100);
		for (int k = 1; k <= 129; k++) begin
			@(posedge clk);
			eccValid <= 1'b1;
			eccWord <= k;
		end
		@(posedge clk);
		eccValid <= 1'b0;
		rd(`OFF_NAND_STS, 32'h00000200, "eccStatus");
		rd(`OFF_NAND_ECC, 32'h00000080, "eccParity");
		wr(`OFF_NAND_CTL, 32'h00000001);
		wr(`OFF_ASYNC_CFG, 32'h3FFFFFFF);
		rd(`OFF_ASYNC_CFG, 32'h3FFFFFFD, "nandWidth");
		$display("test ecc done");
		final_report;
	end
endmodule : tb_top
`default_nettype wire
